// ===== src/sac_pkg.sv
// Shared constants for the servo alarm classifier.
package sac_pkg;

   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] SAC_CONTROL_OFS = 8'h00;
   localparam logic [7:0] SAC_OVERSPEED_OFS = 8'h04;
   localparam logic [7:0] SAC_DEVLIMIT_OFS = 8'h08;
   localparam logic [7:0] SAC_GEARNUM_OFS = 8'h0C;
   localparam logic [7:0] SAC_GEARDEN_OFS = 8'h10;
   localparam logic [7:0] SAC_STATUS_OFS = 8'h14;
   localparam logic [7:0] SAC_MASK_OFS = 8'h18;
   localparam logic [7:0] SAC_INFO_OFS = 8'h1C;

   // Control register fields.
   localparam int SAC_GR1_SEL_LSB = 0;
   localparam int SAC_GR2_SEL_LSB = 4;
   localparam int SAC_ENC_BITS_LSB = 8;

   // Reset values.
   localparam logic [1:0] SAC_GR1_SEL_RST = 2'h0;
   localparam logic [1:0] SAC_GR2_SEL_RST = 2'h0;
   localparam logic [4:0] SAC_ENC_BITS_RST = 5'h14;
   localparam logic [31:0] SAC_OVERSPEED_RST = 32'hFFFFFFFF;
   localparam logic [31:0] SAC_DEVLIMIT_RST = 32'hFFFFFFFF;
   localparam logic [31:0] SAC_GEAR_RST = 32'h00000001;
   localparam logic [8:0] SAC_MASK_RST = 9'h000;

   // Status bit positions, one per alarm source.
   localparam int SAC_NUM_ALARMS = 9;
   localparam int SAC_B_PARAM = 0;
   localparam int SAC_B_OVSPD = 1;
   localparam int SAC_B_OVLD = 2;
   localparam int SAC_B_DEVCNT = 3;
   localparam int SAC_B_DEVPLS = 4;
   localparam int SAC_B_GEAR = 5;
   localparam int SAC_B_CUR1 = 6;
   localparam int SAC_B_GR2 = 7;
   localparam int SAC_B_WARN = 8;

   // Displayed alarm numbers.
   localparam logic [7:0] SAC_NUM_PARAM = 8'h01;
   localparam logic [7:0] SAC_NUM_OVSPD = 8'h03;
   localparam logic [7:0] SAC_NUM_OVLD = 8'h04;
   localparam logic [7:0] SAC_NUM_DEVCNT = 8'h05;
   localparam logic [7:0] SAC_NUM_DEVPLS = 8'h06;
   localparam logic [7:0] SAC_NUM_GEAR = 8'h07;
   localparam logic [7:0] SAC_NUM_CUR1 = 8'h08;

   // Gear ratio range: lower bound 1/1000, upper 4000 at 20 bits.
   localparam logic [63:0] SAC_GEAR_MIN_DEN = 64'h00000000000003E8;
   localparam logic [31:0] SAC_GEAR_MAX_BASE = 32'h00000FA0;
   localparam logic [4:0] SAC_ENC_BITS_BASE = 5'h14;
   localparam logic [4:0] SAC_ENC_BITS_TOP = 5'h18;

   // Panel alternation: half period of the number/glyph swap.
   localparam int SAC_BLINK_MS = 500;
   localparam int SAC_CLK_KHZ = 25000;
   localparam int SAC_BLINK_CYCLES = SAC_BLINK_MS * SAC_CLK_KHZ;

   typedef enum logic [1:0] {
      SAC_CLS_NONE = 2'b00,
      SAC_CLS_GR1 = 2'b01,
      SAC_CLS_GR2 = 2'b10,
      SAC_CLS_WARN = 2'b11
   } sac_class_t;

   typedef enum logic [1:0] {
      SAC_GLYPH_BLANK = 2'b00,
      SAC_GLYPH_FAULT = 2'b01,
      SAC_GLYPH_RUN = 2'b10
   } sac_glyph_t;

endpackage : sac_pkg

// ===== src/sac_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module sac_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1_reg;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("sac_sync needs WIDTH of at least 1.");
      end
   endgenerate

   // Only the second stage reads the first one.
   always_ff @(posedge clk) begin
      if (reset) begin
         stage1_reg <= '0;
         dout <= '0;
      end else begin
         stage1_reg <= din;
         dout <= stage1_reg;
      end
   end

endmodule : sac_sync

// ===== src/sac_alarm_classifier.sv
// Servo alarm detection, classification, stop selection and panel drive.
`timescale 1ns/1ps
module sac_alarm_classifier
   import sac_pkg::*;
#(
   parameter int BLINK_CYCLES = SAC_BLINK_CYCLES,
   parameter logic [7:0] GR2_ALARM_NUM = 8'h20,
   parameter logic [7:0] WARN_ALARM_NUM = 8'h90
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic PARAM_CORRUPT,
   input wire logic OVERLOAD_TRIP,
   input wire logic CUR1_FAULT,
   input wire logic SERVO_ON,
   input wire logic GR2_FAULT,
   input wire logic WARN_EVENT,
   input wire logic [31:0] MOTOR_SPEED,
   input wire logic [31:0] POS_DEVIATION,
   output logic STOP_REQ,
   output logic [1:0] STOP_METHOD,
   output logic [7:0] PANEL_ALARM_NUM,
   output logic PANEL_SHOW_NUM,
   output logic [1:0] PANEL_GLYPH,
   output logic IRQ
);

   generate
      if (BLINK_CYCLES < 2) begin : g_bad_blink
         $error("BLINK_CYCLES must be at least 2.");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Functions.

   function automatic sac_class_t alarm_class(input int idx);
      sac_class_t c;
      c = SAC_CLS_GR1;
      if (idx == SAC_B_GR2) begin
         c = SAC_CLS_GR2;
      end else if (idx == SAC_B_WARN) begin
         c = SAC_CLS_WARN;
      end
      return c;
   endfunction : alarm_class

   function automatic logic [7:0] alarm_number(input int idx);
      logic [7:0] n;
      case (idx)
         SAC_B_PARAM: n = SAC_NUM_PARAM;
         SAC_B_OVSPD: n = SAC_NUM_OVSPD;
         SAC_B_OVLD: n = SAC_NUM_OVLD;
         SAC_B_DEVCNT: n = SAC_NUM_DEVCNT;
         SAC_B_DEVPLS: n = SAC_NUM_DEVPLS;
         SAC_B_GEAR: n = SAC_NUM_GEAR;
         SAC_B_CUR1: n = SAC_NUM_CUR1;
         SAC_B_GR2: n = GR2_ALARM_NUM;
         default: n = WARN_ALARM_NUM;
      endcase
      return n;
   endfunction : alarm_number

   // Upper gear bound doubles per encoder bit from 20 up to 24.
   function automatic logic [63:0] gear_upper(input logic [4:0] bits);
      logic [4:0] b;
      b = bits;
      if (b < SAC_ENC_BITS_BASE) begin
         b = SAC_ENC_BITS_BASE;
      end else if (b > SAC_ENC_BITS_TOP) begin
         b = SAC_ENC_BITS_TOP;
      end
      return {32'h00000000, SAC_GEAR_MAX_BASE} << (b - SAC_ENC_BITS_BASE);
   endfunction : gear_upper

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic [5:0] pins_sync;

   sac_sync #(
      .WIDTH(6)
   ) u_sync (
      .clk(CLK),
      .reset(RESET),
      .din({WARN_EVENT, GR2_FAULT, SERVO_ON, CUR1_FAULT, OVERLOAD_TRIP,
            PARAM_CORRUPT}),
      .dout(pins_sync)
   );

   logic param_bad;
   logic ovld;
   logic cur1_bad;
   logic servo_on;
   logic gr2_ev;
   logic warn_ev;
   assign {warn_ev, gr2_ev, servo_on, cur1_bad, ovld, param_bad} = pins_sync;

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY.

   logic [1:0] gr1_sel_reg;
   logic [1:0] gr2_sel_reg;
   logic [4:0] enc_bits_reg;
   logic [31:0] overspeed_reg;
   logic [31:0] dev_limit_reg;
   logic [31:0] gear_num_reg;
   logic [31:0] gear_den_reg;
   logic [8:0] status_reg;
   logic [8:0] status_next;
   logic [8:0] mask_reg;
   logic [7:0] info_num;
   sac_class_t info_cls;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic addr_valid;

   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign addr_valid = HSEL && HREADY && HTRANS[1];

   always_ff @(posedge CLK) begin
      if (RESET) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_valid && HWRITE;
         wr_addr_reg <= HADDR[7:0];
      end
   end

   // Read data are captured at the address phase edge.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         HRDATA <= 32'h00000000;
      end else if (addr_valid && !HWRITE) begin
         case (HADDR[7:0])
            SAC_CONTROL_OFS: HRDATA <= {19'h00000, enc_bits_reg, 2'h0,
                                        gr2_sel_reg, 2'h0, gr1_sel_reg};
            SAC_OVERSPEED_OFS: HRDATA <= overspeed_reg;
            SAC_DEVLIMIT_OFS: HRDATA <= dev_limit_reg;
            SAC_GEARNUM_OFS: HRDATA <= gear_num_reg;
            SAC_GEARDEN_OFS: HRDATA <= gear_den_reg;
            SAC_STATUS_OFS: HRDATA <= {23'h000000, status_reg};
            SAC_MASK_OFS: HRDATA <= {23'h000000, mask_reg};
            SAC_INFO_OFS: HRDATA <= {21'h000000, STOP_REQ, info_cls,
                                     info_num};
            default: HRDATA <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         gr1_sel_reg <= SAC_GR1_SEL_RST;
         gr2_sel_reg <= SAC_GR2_SEL_RST;
         enc_bits_reg <= SAC_ENC_BITS_RST;
      end else if (wr_pend_reg && wr_addr_reg == SAC_CONTROL_OFS) begin
         gr1_sel_reg <= HWDATA[SAC_GR1_SEL_LSB +: 2];
         gr2_sel_reg <= HWDATA[SAC_GR2_SEL_LSB +: 2];
         enc_bits_reg <= HWDATA[SAC_ENC_BITS_LSB +: 5];
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         overspeed_reg <= SAC_OVERSPEED_RST;
         dev_limit_reg <= SAC_DEVLIMIT_RST;
         gear_num_reg <= SAC_GEAR_RST;
         gear_den_reg <= SAC_GEAR_RST;
         mask_reg <= SAC_MASK_RST;
      end else if (wr_pend_reg) begin
         case (wr_addr_reg)
            SAC_OVERSPEED_OFS: overspeed_reg <= HWDATA;
            SAC_DEVLIMIT_OFS: dev_limit_reg <= HWDATA;
            SAC_GEARNUM_OFS: gear_num_reg <= HWDATA;
            SAC_GEARDEN_OFS: gear_den_reg <= HWDATA;
            SAC_MASK_OFS: mask_reg <= HWDATA[8:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Detection.

   logic [31:0] dev_abs;
   logic [63:0] num_wide;
   logic [63:0] den_wide;
   logic gear_bad;
   logic servo_on_d_reg;
   logic [8:0] detect;

   assign dev_abs = POS_DEVIATION[31] ? 32'(-POS_DEVIATION) : POS_DEVIATION;
   assign num_wide = {32'h00000000, gear_num_reg};
   assign den_wide = {32'h00000000, gear_den_reg};

   // Cross-multiplied so no divider is needed.
   assign gear_bad = (gear_den_reg == 32'h00000000) ||
                     (num_wide * SAC_GEAR_MIN_DEN < den_wide) ||
                     (num_wide > den_wide * gear_upper(enc_bits_reg));

   always_ff @(posedge CLK) begin
      if (RESET) begin
         servo_on_d_reg <= 1'b0;
      end else begin
         servo_on_d_reg <= servo_on;
      end
   end

   always_comb begin
      detect = '0;
      detect[SAC_B_PARAM] = param_bad;
      detect[SAC_B_OVSPD] = MOTOR_SPEED > overspeed_reg;
      detect[SAC_B_OVLD] = ovld;
      detect[SAC_B_DEVCNT] = servo_on && dev_abs > dev_limit_reg;
      // Deviation piled up while off is judged at the servo-on edge.
      detect[SAC_B_DEVPLS] = servo_on && !servo_on_d_reg && !gear_bad &&
         ({32'h00000000, dev_abs} * den_wide >
          {32'h00000000, dev_limit_reg} * num_wide);
      detect[SAC_B_GEAR] = gear_bad;
      detect[SAC_B_CUR1] = cur1_bad;
      detect[SAC_B_GR2] = gr2_ev;
      detect[SAC_B_WARN] = warn_ev;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky status: write one to clear, a new event wins over the clear.

   always_comb begin
      status_next = status_reg;
      if (wr_pend_reg && wr_addr_reg == SAC_STATUS_OFS) begin
         status_next = status_reg & ~HWDATA[8:0];
      end
      status_next = status_next | detect;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(status_reg & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Classification and stop selection.

   logic any_gr1;
   logic any_gr2;
   logic any_warn;

   // Lowest status bit wins the display; the first group sits lowest.
   always_comb begin
      info_num = 8'h00;
      info_cls = SAC_CLS_NONE;
      any_gr1 = 1'b0;
      any_gr2 = 1'b0;
      any_warn = 1'b0;
      for (int i = SAC_NUM_ALARMS - 1; i >= 0; i--) begin
         if (status_reg[i]) begin
            info_num = alarm_number(i);
            info_cls = alarm_class(i);
            if (alarm_class(i) == SAC_CLS_GR1) begin
               any_gr1 = 1'b1;
            end else if (alarm_class(i) == SAC_CLS_GR2) begin
               any_gr2 = 1'b1;
            end else begin
               any_warn = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         STOP_REQ <= 1'b0;
         STOP_METHOD <= 2'h0;
      end else if (any_gr1) begin
         STOP_REQ <= 1'b1;
         STOP_METHOD <= gr1_sel_reg;
      end else if (any_gr2) begin
         STOP_REQ <= 1'b1;
         STOP_METHOD <= gr2_sel_reg;
      end else begin
         // A warning alone leaves the drive running as it was.
         STOP_REQ <= 1'b0;
         STOP_METHOD <= 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Panel: number and state glyph take turns every blink period.

   logic [31:0] blink_cnt_reg;
   logic phase_reg;

   always_ff @(posedge CLK) begin
      if (RESET || info_cls == SAC_CLS_NONE) begin
         blink_cnt_reg <= 32'h00000000;
         phase_reg <= 1'b1;
      end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
         blink_cnt_reg <= 32'h00000000;
         phase_reg <= !phase_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         PANEL_ALARM_NUM <= 8'h00;
         PANEL_SHOW_NUM <= 1'b0;
         PANEL_GLYPH <= SAC_GLYPH_BLANK;
      end else begin
         PANEL_ALARM_NUM <= info_num;
         PANEL_SHOW_NUM <= (info_cls != SAC_CLS_NONE) && phase_reg;
         if (info_cls == SAC_CLS_NONE || phase_reg) begin
            PANEL_GLYPH <= SAC_GLYPH_BLANK;
         end else if (any_gr1 || any_gr2) begin
            PANEL_GLYPH <= SAC_GLYPH_FAULT;
         end else if (any_warn) begin
            PANEL_GLYPH <= SAC_GLYPH_RUN;
         end else begin
            PANEL_GLYPH <= SAC_GLYPH_BLANK;
         end
      end
   end

endmodule : sac_alarm_classifier

// ===== bench/sac_alarm_classifier_props.sv
// Port-level assertions for the servo alarm classifier.
`timescale 1ns/1ps
module sac_alarm_classifier_props
   import sac_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic PARAM_CORRUPT,
   input wire logic CUR1_FAULT,
   input wire logic GR2_FAULT,
   input wire logic STOP_REQ,
   input wire logic [1:0] STOP_METHOD,
   input wire logic [7:0] PANEL_ALARM_NUM,
   input wire logic PANEL_SHOW_NUM,
   input wire logic [1:0] PANEL_GLYPH
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   logic wr_take;
   assign wr_take = HSEL && HREADY && HTRANS[1] && HWRITE;
   ////////////////////////////////////////////////////////////////////////
   // Pin causes show on the stop output four cycles after the pin is sampled, checked at five.
   a_param_stop: assert property (PARAM_CORRUPT |-> ##5 STOP_REQ)
      else $error("parameter fault did not stop");
   a_cur1_stop: assert property (CUR1_FAULT |-> ##5 STOP_REQ)
      else $error("current channel fault did not stop");
   a_gr2_stop: assert property (GR2_FAULT |-> ##5 STOP_REQ)
      else $error("group two fault did not stop");
   // A stop may only end after a status write has landed.
   a_stop_fall: assert property ($fell(STOP_REQ) |->
      $past(wr_take, 2) || $past(wr_take, 3) || $past(wr_take, 4))
      else $error("stop released without a clear");
   a_method_idle: assert property (
      !STOP_REQ |-> STOP_METHOD == 2'h0)
      else $error("stop method set while not stopping");
   a_run_glyph: assert property (
      PANEL_GLYPH == SAC_GLYPH_RUN |-> !STOP_REQ)
      else $error("run glyph shown while stopping");
   a_show_num: assert property (
      PANEL_SHOW_NUM |-> PANEL_ALARM_NUM != 8'h00)
      else $error("number phase without a number");
   a_glyph_ok: assert property (PANEL_GLYPH != 2'h3)
      else $error("glyph code out of range");
endmodule : sac_alarm_classifier_props

// ===== bench/sac_motor_panel.sv
// Behavioural motor power stage driven by the stop request.
`timescale 1ns/1ps
module sac_motor_panel (
   input wire logic clk,
   input wire logic reset,
   input wire logic stop_req,
   output logic running
);
   // The motor coasts on only while no stop is requested.
   always_ff @(posedge clk) begin
      if (reset) begin
         running <= 1'b1;
      end else begin
         running <= !stop_req;
      end
   end
endmodule : sac_motor_panel

// ===== bench/sac_alarm_classifier_tb.sv
// Self-checking bench for the servo alarm classifier.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch %0t got %h exp %h", $time, (a), (b)); end end
module sac_alarm_classifier_tb
   import sac_pkg::*;
;
   localparam int BL = 8;
   localparam logic [7:0] GN = 8'h20;
   localparam logic [7:0] WN = 8'h90;
   logic CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
   logic [31:0] MOTOR_SPEED = 32'h0, POS_DEVIATION = 32'h0;
   logic [1:0] HTRANS = 2'h0, STOP_METHOD, PANEL_GLYPH;
   logic [2:0] HSIZE = 3'h2;
   logic HREADYOUT, HRESP, STOP_REQ, PANEL_SHOW_NUM, IRQ, run;
   logic [7:0] PANEL_ALARM_NUM;
   logic [5:0] pin = 6'h0;
   logic [31:0] d, lim, g1, g2;
   int miscompares = 0, n_checks = 0, cyc = 0;
   int pb[5] = '{SAC_B_PARAM, SAC_B_OVLD, SAC_B_CUR1, SAC_B_GR2, SAC_B_WARN};
   logic [7:0] pn[5] = '{SAC_NUM_PARAM, SAC_NUM_OVLD, SAC_NUM_CUR1, GN, WN};
   logic [31:0] gn[6] = '{32'h1, 32'h1, 32'hFA0, 32'hFA1, 32'hFA00, 32'hFA01};
   logic [31:0] gd[6] = '{32'h3E8, 32'h3E9, 32'h1, 32'h1, 32'h1, 32'h1};
   logic [4:0] gb[6] = '{5'h14, 5'h14, 5'h14, 5'h14, 5'h18, 5'h18};
   sac_alarm_classifier #(.BLINK_CYCLES(BL), .GR2_ALARM_NUM(GN),
      .WARN_ALARM_NUM(WN)) DUT (.CLK(CLK), .RESET(RESET), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PARAM_CORRUPT(pin[0]),
      .OVERLOAD_TRIP(pin[1]), .CUR1_FAULT(pin[2]), .GR2_FAULT(pin[3]),
      .WARN_EVENT(pin[4]), .SERVO_ON(pin[5]), .MOTOR_SPEED(MOTOR_SPEED),
      .POS_DEVIATION(POS_DEVIATION), .STOP_REQ(STOP_REQ),
      .STOP_METHOD(STOP_METHOD), .PANEL_ALARM_NUM(PANEL_ALARM_NUM),
      .PANEL_SHOW_NUM(PANEL_SHOW_NUM), .PANEL_GLYPH(PANEL_GLYPH), .IRQ(IRQ));
   sac_motor_panel PM (.clk(CLK), .reset(RESET), .stop_req(STOP_REQ),
      .running(run));
   always #20 CLK = ~CLK;
   // Bounds a hung handshake; the full run needs well under this.
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic clk(int n);
      repeat (n) @(posedge CLK);
   endtask : clk
   // One AHB-Lite single transfer; the idle edge first keeps drives apart.
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] wd);
      @(posedge CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= wd;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      d = HRDATA;
   endtask : xfer
   task automatic wr(logic [7:0] a, logic [31:0] v);
      xfer(1'b1, a, v);
   endtask : wr
   task automatic rc(logic [7:0] a, logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(d, e)
      `CHK(HRESP, 1'b0)
   endtask : rc
   task automatic sc(logic [31:0] e);
      clk(6);
      rc(SAC_STATUS_OFS, e);
   endtask : sc
   function automatic sac_class_t cls_of(int b);
      if (b == SAC_B_GR2) return SAC_CLS_GR2;
      if (b == SAC_B_WARN) return SAC_CLS_WARN;
      return SAC_CLS_GR1;
   endfunction : cls_of
   function automatic logic [1:0] mth(sac_class_t c);
      return c == SAC_CLS_GR1 ? g1[1:0] : c == SAC_CLS_GR2 ? g2[1:0] : 2'h0;
   endfunction : mth
   function automatic logic [31:0] ctl(logic [4:0] eb);
      return {19'h0, eb, 2'h0, g2[1:0], 2'h0, g1[1:0]};
   endfunction : ctl
   // A panel that never toggles is caught by the cycle ceiling.
   task automatic w_show(logic v);
      while (PANEL_SHOW_NUM !== v) @(posedge CLK);
   endtask : w_show
   task automatic alarm(int i);
      int b;
      sac_class_t c;
      logic [31:0] m;
      logic [1:0] ge;
      b = pb[i];
      c = cls_of(b);
      ge = c == SAC_CLS_WARN ? SAC_GLYPH_RUN : SAC_GLYPH_FAULT;
      m = $urandom % 32'h200;
      wr(SAC_MASK_OFS, m);
      @(posedge CLK) pin <= 6'h01 << i;
      clk(7);
      `CHK(STOP_REQ, c != SAC_CLS_WARN)
      `CHK(STOP_METHOD, mth(c))
      `CHK(run, c == SAC_CLS_WARN)
      `CHK(IRQ, m[b])
      rc(SAC_INFO_OFS, {21'h0, c != SAC_CLS_WARN, c, pn[i]});
      rc(SAC_STATUS_OFS, 32'h1 << b);
      if (c != SAC_CLS_GR2) begin
         w_show(1'b0);
         `CHK(PANEL_GLYPH, ge)
         w_show(1'b1);
         `CHK(PANEL_ALARM_NUM, pn[i])
      end
      @(posedge CLK) pin <= 6'h00;
      sc(32'h1 << b);
      wr(SAC_STATUS_OFS, 32'h1 << b);
      rc(SAC_STATUS_OFS, 32'h0);
      `CHK({STOP_REQ, IRQ, PANEL_SHOW_NUM}, 3'b000)
      $display("test alarm %0d done", i);
   endtask : alarm
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hE08B));
      g1 = $urandom % 4;
      g2 = $urandom % 4;
      lim = 32'h64 + $urandom % 32'h384;
      clk(8);
      RESET <= 1'b0;
      rc(SAC_CONTROL_OFS, ctl(SAC_ENC_BITS_RST) & 32'h1F00);
      rc(SAC_STATUS_OFS, 32'h0);
      rc(SAC_INFO_OFS, 32'h0);
      rc(8'h20, 32'h0);
      wr(SAC_CONTROL_OFS, ctl(5'h14));
      rc(SAC_CONTROL_OFS, ctl(5'h14));
      $display("test reset done");
      for (int i = 0; i < 5; i++) alarm(i);
      wr(SAC_OVERSPEED_OFS, lim);
      @(posedge CLK) MOTOR_SPEED <= lim;
      sc(32'h0);
      @(posedge CLK) MOTOR_SPEED <= lim + 32'h1;
      sc(32'h1 << SAC_B_OVSPD);
      @(posedge CLK) MOTOR_SPEED <= 32'h0;
      wr(SAC_STATUS_OFS, 32'h1FF);
      $display("test overspeed done");
      wr(SAC_DEVLIMIT_OFS, lim);
      wr(SAC_GEARNUM_OFS, 32'h2);
      @(posedge CLK) POS_DEVIATION <= -(lim + 32'h1);
      sc(32'h0);
      @(posedge CLK) pin[5] <= 1'b1;
      sc(32'h1 << SAC_B_DEVCNT);
      @(posedge CLK) pin[5] <= 1'b0;
      POS_DEVIATION <= -(2 * lim + 32'h1);
      clk(3);
      wr(SAC_STATUS_OFS, 32'h1FF);
      sc(32'h0);
      @(posedge CLK) pin[5] <= 1'b1;
      sc(32'h18);
      @(posedge CLK) pin[5] <= 1'b0;
      POS_DEVIATION <= 32'h0;
      clk(3);
      wr(SAC_STATUS_OFS, 32'h1FF);
      $display("test deviation done");
      for (int i = 0; i < 6; i++) begin
         wr(SAC_CONTROL_OFS, ctl(gb[i]));
         wr(SAC_GEARNUM_OFS, gn[i]);
         wr(SAC_GEARDEN_OFS, gd[i]);
         wr(SAC_STATUS_OFS, 32'h1FF);
         sc(i % 2 ? 32'h20 : 32'h0);
      end
      wr(SAC_GEARNUM_OFS, 32'h1);
      wr(SAC_STATUS_OFS, 32'h1FF);
      sc(32'h0);
      $display("test gear done");
      close_out();
   end
endmodule : sac_alarm_classifier_tb
bind sac_alarm_classifier sac_alarm_classifier_props u_props (.CLK(CLK),
   .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HREADY(HREADY), .PARAM_CORRUPT(PARAM_CORRUPT), .CUR1_FAULT(CUR1_FAULT),
   .GR2_FAULT(GR2_FAULT), .STOP_REQ(STOP_REQ), .STOP_METHOD(STOP_METHOD),
   .PANEL_ALARM_NUM(PANEL_ALARM_NUM), .PANEL_SHOW_NUM(PANEL_SHOW_NUM),
   .PANEL_GLYPH(PANEL_GLYPH));
